/* File: logic/gdrv_pkg.sv */
// shared types, offsets and reset values of the gate driver register bank
package gdrv_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_CONFIG = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_DTIME  = 32'h0000_0008;

    // global_config field positions
    localparam int CFG_GAIN_LSB = 4;
    localparam int CFG_AMP_OFF  = 6;
    localparam int CFG_TEST     = 7;

    // flag positions in global_status_flags
    localparam int FLG_RESET    = 0;
    localparam int FLG_PREWARN  = 1;
    localparam int FLG_OVERTEMP = 2;
    localparam int FLG_CP_UNDERVOLT = 3;
    localparam int FLG_SHORT    = 4;

    // synchronised pin positions
    localparam int PIN_DRV_EN  = 0;
    localparam int PIN_PREWARN = 1;
    localparam int PIN_OVER    = 2;
    localparam int PIN_CP_UNDERVOLT = 3;
    localparam int PIN_SHORT   = 4;
    localparam int PIN_GATE_ON = 5;

    // values after reset and encodings
    localparam logic [7:0] CFG_RESET   = 8'h00;
    localparam logic [1:0] DTIME_RESET = 2'h0;
    localparam logic [4:0] FLAGS_RESET = 5'h01;
    localparam logic [4:0] PIN_CYCLE_CLR = 5'h1C;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [4:0] GAIN_X5     = 5'h05;
    localparam logic [4:0] GAIN_X10    = 5'h0A;
    localparam logic [4:0] GAIN_X20    = 5'h14;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic drv_en;
        logic temp_prewarn;
        logic temp_over;
        logic cp_undervolt;
        logic short_event;
        logic gate_inputs_on;
    } pin_in_t;

    typedef struct packed {
        logic [4:0] gain;
        logic       amp_on;
        logic       test_en;
        logic [1:0] test_src;
        logic       shutdown;
        logic       fault;
        logic       gate_block;
    } pin_out_t;

    // gain code to amplification factor
    function automatic logic [4:0] gain_decode(input logic [1:0] code);
        gain_decode = (code == 2'h0) ? GAIN_X5 : (code == 2'h3) ? GAIN_X20 : GAIN_X10;
    endfunction

endpackage

/* File: logic/gdrv_regs.sv */
// global configuration and status register bank behind an axi4-lite slave
// Notes on behaviour
// RULE1: gain code 0 gives 5, codes 1 and 2 give 10, code 3 gives 20.
// RULE2: config bit 6 at 1 powers the sense amplifiers down, at 0 keeps them on.
// RULE3: config bit 7 routes a test signal to the enable pin, source from dead_time_setting.
// RULE4: the host keeps config bit 7 at 0 in normal use.
// RULE5: config sits at offset 0, read-write, bits 31:8 unused and read zero.
// RULE6: writing one to a status bit clears it, writing zero leaves it.
// RULE7: cycling the enable pin clears all status flags but reset and prewarning.
// RULE8: clearing the short flag does not release the gate until its inputs go off.
// RULE9: any reset restores all registers and sets the reset flag at bit 0.
// RULE10: the reset flag clears only while the enable pin is high.
// RULE11: the prewarning flag latches on high temperature and takes no action.
// RULE12: overtemperature shuts the driver down and latches bit 2.
// RULE13: the overtemperature flag will not clear while temperature is over the limit.
// RULE14: the overtemperature flag is ORed into the fault output.
// RULE15: a flag set in the cycle it is cleared stays set.
`timescale 1ns/100ps
module gdrv_regs
    import gdrv_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire axi_req_t bus_req,
    output axi_rsp_t      bus_rsp,
    input  wire pin_in_t  pins_in,
    output pin_out_t      pins_out
);

    typedef struct packed {
        logic [5:0]  sync1;
        logic [5:0]  sync2;
        logic        en_prev;
        logic [7:0]  cfg;
        logic [1:0]  dtime;
        logic [4:0]  flags;
        logic        aw_got;
        logic        w_got;
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic        wstrb0;
        axi_rsp_t    rsp;
        pin_out_t    pout;
    } state_t;

    localparam state_t STATE_RESET = '{
        sync1:   6'h00,
        sync2:   6'h00,
        en_prev: 1'b0,
        cfg:     CFG_RESET,
        dtime:   DTIME_RESET,
        flags:   FLAGS_RESET,
        aw_got:  1'b0,
        w_got:   1'b0,
        waddr:   32'h0000_0000,
        wdata:   32'h0000_0000,
        wstrb0:  1'b0,
        rsp:     '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
                   arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY},
        pout:    '{gain: GAIN_X5, amp_on: 1'b1, test_en: 1'b0, test_src: DTIME_RESET,
                   shutdown: 1'b0, fault: 1'b0, gate_block: 1'b0}
    };

    state_t     s_reg;
    state_t     s_next;
    logic [5:0] pin_vec;
    logic       en;
    logic       en_rise;
    logic       do_write;
    logic [4:0] set_vec;

    // pins gathered for the two-stage synchroniser
    assign pin_vec = {pins_in.gate_inputs_on, pins_in.short_event, pins_in.cp_undervolt,
                      pins_in.temp_over, pins_in.temp_prewarn, pins_in.drv_en};

    // synchronised pin views
    assign en       = s_reg.sync2[PIN_DRV_EN];
    assign en_rise  = en & ~s_reg.en_prev;
    assign do_write = s_reg.aw_got & s_reg.w_got & ~s_reg.rsp.bvalid;

    // hardware events that set flags
    assign set_vec = {s_reg.sync2[PIN_SHORT], s_reg.sync2[PIN_CP_UNDERVOLT],
                      s_reg.sync2[PIN_OVER], s_reg.sync2[PIN_PREWARN], 1'b0};

    // next state of the whole bank
    always_comb begin
        logic [4:0] clr;
        clr = 5'h00;
        s_next = s_reg;
        s_next.sync1 = pin_vec;
        s_next.sync2 = s_reg.sync1;
        s_next.en_prev = en;

        // write address and data taken in either order
        if (s_reg.rsp.awready && bus_req.awvalid) begin
            s_next.aw_got = 1'b1;
            s_next.waddr = bus_req.awaddr;
        end
        if (s_reg.rsp.wready && bus_req.wvalid) begin
            s_next.w_got = 1'b1;
            s_next.wdata = bus_req.wdata;
            s_next.wstrb0 = bus_req.wstrb[0];
        end

        // perform write once both halves are held
        if (do_write) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp = RESP_OKAY;
            if (s_reg.waddr == ADDR_CONFIG) begin
                if (s_reg.wstrb0) begin
                    s_next.cfg = s_reg.wdata[7:0]; // RULE5
                end
            end else if (s_reg.waddr == ADDR_STATUS) begin
                if (s_reg.wstrb0) begin
                    clr = s_reg.wdata[4:0]; // RULE6
                end
            end else if (s_reg.waddr == ADDR_DTIME) begin
                if (s_reg.wstrb0) begin
                    s_next.dtime = s_reg.wdata[1:0];
                end
            end else begin
                s_next.rsp.bresp = RESP_SLVERR;
            end
        end
        if (s_reg.rsp.bvalid && bus_req.bready) begin
            s_next.rsp.bvalid = 1'b0;
        end
        s_next.rsp.awready = ~s_next.aw_got & ~s_next.rsp.bvalid;
        s_next.rsp.wready = ~s_next.w_got & ~s_next.rsp.bvalid;

        // read answer, one outstanding at a time
        if (s_reg.rsp.rvalid && bus_req.rready) begin
            s_next.rsp.rvalid = 1'b0;
        end
        if (s_reg.rsp.arready && bus_req.arvalid) begin
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rresp = RESP_OKAY;
            if (bus_req.araddr == ADDR_CONFIG) begin
                s_next.rsp.rdata = {24'h00_0000, s_reg.cfg}; // RULE5
            end else if (bus_req.araddr == ADDR_STATUS) begin
                s_next.rsp.rdata = {27'h0, s_reg.flags};
            end else if (bus_req.araddr == ADDR_DTIME) begin
                s_next.rsp.rdata = {30'h0, s_reg.dtime};
            end else begin
                s_next.rsp.rdata = 32'h0000_0000;
                s_next.rsp.rresp = RESP_SLVERR;
            end
        end
        s_next.rsp.arready = ~s_next.rsp.rvalid;

        // enable pin cycle clears the protective flags
        if (en_rise) begin
            clr = clr | PIN_CYCLE_CLR; // RULE7
        end
        clr[FLG_RESET] = clr[FLG_RESET] & en; // RULE10
        clr[FLG_OVERTEMP] = clr[FLG_OVERTEMP] & ~s_reg.sync2[PIN_OVER]; // RULE13

        // set beats clear
        s_next.flags = (s_reg.flags & ~clr) | set_vec; // RULE11 RULE12 RULE15

        // gate stays blocked until the short is cleared and inputs are off
        if (set_vec[FLG_SHORT]) begin
            s_next.pout.gate_block = 1'b1;
        end else if (!s_next.flags[FLG_SHORT] && !s_reg.sync2[PIN_GATE_ON]) begin
            s_next.pout.gate_block = 1'b0; // RULE8
        end

        // registered pin outputs
        s_next.pout.gain = gain_decode(s_next.cfg[CFG_GAIN_LSB +: 2]); // RULE1
        s_next.pout.amp_on = ~s_next.cfg[CFG_AMP_OFF]; // RULE2
        s_next.pout.test_en = s_next.cfg[CFG_TEST]; // RULE3
        s_next.pout.test_src = s_next.dtime; // RULE3
        s_next.pout.shutdown = s_next.flags[FLG_OVERTEMP]; // RULE12
        s_next.pout.fault = s_next.flags[FLG_OVERTEMP] | s_next.flags[FLG_SHORT]; // RULE14
    end

    // single state register, synchronous reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= STATE_RESET; // RULE9
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus_rsp = s_reg.rsp;
    assign pins_out = s_reg.pout;

    // gain factor follows the configured code
    a_gain_code: assert property ( // RULE1
        @(posedge clk) disable iff (rst)
        (s_reg.cfg[5:4] == 2'h3) |-> (s_reg.pout.gain == 5'h14)
    ) else $error("gain code 3 not giving twenty");

    // amplifier power follows the disable bit
    a_amp_power: assert property ( // RULE2
        @(posedge clk) disable iff (rst)
        s_reg.pout.amp_on == !s_reg.cfg[6]
    ) else $error("amplifier power disagrees with config");

    // test output routed with chosen source
    a_test_route: assert property ( // RULE3
        @(posedge clk) disable iff (rst)
        s_reg.cfg[7] |-> (s_reg.pout.test_en && s_reg.pout.test_src == s_reg.dtime)
    ) else $error("test route wrong");

    // reset flag up right after reset
    a_reset_flag: assert property ( // RULE9
        @(posedge clk) disable iff (rst)
        $past(rst) |-> (s_reg.flags[0] && s_reg.cfg == 8'h00)
    ) else $error("reset flag or config wrong after reset");

    // write one clears undervoltage flag
    a_w1c_clear: assert property ( // RULE6
        @(posedge clk) disable iff (rst)
        (do_write && s_reg.waddr == 32'h0000_0004 && s_reg.wstrb0 && s_reg.wdata[3]
            && !s_reg.sync2[3]) |=> !s_reg.flags[3]
    ) else $error("write one did not clear flag");

    // enable cycle clears short and undervoltage flags
    a_pin_cycle: assert property ( // RULE7
        @(posedge clk) disable iff (rst)
        (en_rise && !s_reg.sync2[4] && !s_reg.sync2[3]) |=> (!s_reg.flags[4] && !s_reg.flags[3])
    ) else $error("enable cycle did not clear flags");

    // reset flag held while enable low
    a_reset_hold: assert property ( // RULE10
        @(posedge clk) disable iff (rst)
        (s_reg.flags[0] && !en) |=> s_reg.flags[0]
    ) else $error("reset flag cleared with enable low");

    // overtemperature flag held while hot
    a_ot_hold: assert property ( // RULE13
        @(posedge clk) disable iff (rst)
        (s_reg.flags[2] && s_reg.sync2[2]) |=> s_reg.flags[2]
    ) else $error("overtemperature flag cleared while hot");

    // fault and shutdown follow overtemperature
    a_fault_pin: assert property ( // RULE14
        @(posedge clk) disable iff (rst)
        s_reg.flags[2] |-> (s_reg.pout.fault && s_reg.pout.shutdown)
    ) else $error("fault output not set by overtemperature");

    // prewarning event always lands
    a_set_wins: assert property ( // RULE15
        @(posedge clk) disable iff (rst)
        s_reg.sync2[1] |=> s_reg.flags[1]
    ) else $error("prewarning event lost");

    // gate stays blocked while inputs on
    a_short_block: assert property ( // RULE8
        @(posedge clk) disable iff (rst)
        (s_reg.pout.gate_block && s_reg.sync2[5]) |=> s_reg.pout.gate_block
    ) else $error("gate released with inputs on");

    // lowest gain code gives five
    a_gain_low: assert property ( // RULE1
        @(posedge clk) disable iff (rst)
        (s_reg.cfg[5:4] == 2'h0) |-> (s_reg.pout.gain == 5'h05)
    ) else $error("gain code 0 not giving five");

    // both middle gain codes give ten
    a_gain_mid: assert property ( // RULE1
        @(posedge clk) disable iff (rst)
        (s_reg.cfg[5:4] == 2'h1 || s_reg.cfg[5:4] == 2'h2) |-> (s_reg.pout.gain == 5'h0A)
    ) else $error("gain code 1 or 2 not giving ten");

    // unused upper bits read back as zero
    a_read_upper: assert property ( // RULE5
        @(posedge clk) disable iff (rst)
        s_reg.rsp.rvalid |-> (s_reg.rsp.rdata[31:8] == 24'h00_0000)
    ) else $error("upper read data bits not zero");

    // writing zero leaves a flag alone
    a_w1c_keep: assert property ( // RULE6
        @(posedge clk) disable iff (rst)
        (do_write && s_reg.waddr == 32'h0000_0004 && !s_reg.wdata[1] && s_reg.flags[1])
            |=> s_reg.flags[1]
    ) else $error("zero write cleared a flag");

    // enable cycle keeps the reset flag
    a_cycle_keeps: assert property ( // RULE7
        @(posedge clk) disable iff (rst)
        (en_rise && !do_write && s_reg.flags[0]) |=> s_reg.flags[0]
    ) else $error("enable cycle cleared the reset flag");

    // prewarning alone never shuts down
    a_prewarn_quiet: assert property ( // RULE11
        @(posedge clk) disable iff (rst)
        !s_reg.flags[2] |-> !s_reg.pout.shutdown
    ) else $error("shutdown without overtemperature flag");

    // overtemperature latches and shuts down
    a_ot_latch: assert property ( // RULE12
        @(posedge clk) disable iff (rst)
        s_reg.sync2[2] |=> (s_reg.flags[2] && s_reg.pout.shutdown)
    ) else $error("overtemperature not latched");

    // short event always lands and blocks the gate
    a_short_latch: assert property ( // RULE15
        @(posedge clk) disable iff (rst)
        s_reg.sync2[4] |=> (s_reg.flags[4] && s_reg.pout.gate_block)
    ) else $error("short event lost");

endmodule

/* File: test/pin_env.sv */
// pin side model: temperature, supply, short and gate input levels
`timescale 1ns/100ps
module pin_env
    import gdrv_pkg::*;
(
    input  wire logic     clk,
    input  wire pin_in_t  want,
    input  wire pin_out_t pins_out,
    output pin_in_t       pins_in
);
    pin_in_t held;

    // gate inputs driven off while the driver holds the gate blocked
    always_comb begin
        held = want;
        held.gate_inputs_on = want.gate_inputs_on & ~pins_out.gate_block;
    end

    // pin levels change once per clock
    always_ff @(posedge clk) begin
        pins_in <= held;
    end
endmodule

/* File: test/gate_driver_config_status_regs_test.sv */
// self-checking bench of the gate driver register bank
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module gate_driver_config_status_regs_test;
    import gdrv_pkg::*;
    logic        clk = 0;
    logic        rst = 1;
    axi_req_t    req = '0;
    axi_rsp_t    rsp;
    pin_in_t     want = '0;
    pin_in_t     pins_in;
    pin_out_t    pins_out;
    int          miscompares = 0;
    int          tests_run = 0;
    logic [31:0] s = 32'h5C8B;
    logic [31:0] d;
    logic [31:0] v;
    logic [1:0]  r;

    always #50 clk = ~clk;

    gdrv_regs gdrv_regs_i (.clk(clk), .rst(rst), .bus_req(req), .bus_rsp(rsp),
        .pins_in(pins_in), .pins_out(pins_out));
    pin_env pin_env_i (.clk(clk), .want(want), .pins_out(pins_out), .pins_in(pins_in));

    // random source and expected gain
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [4:0] exp_gain(input logic [1:0] c);
        exp_gain = (c == 2'h0) ? 5'h05 : (c == 2'h3) ? 5'h14 : 5'h0A;
    endfunction

    task automatic tally_and_finish;
        if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one axi4-lite write, held until each channel is taken
    task automatic wr(input logic [31:0] a, input logic [31:0] dat, output logic [1:0] rs);
        int n;
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= dat;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                rs = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin miscompares++; tally_and_finish(); end
    endtask
    // one axi4-lite read
    task automatic rd(input logic [31:0] a, output logic [31:0] dat, output logic [1:0] rs);
        int n;
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                dat = rsp.rdata;
                rs = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin miscompares++; tally_and_finish(); end
    endtask
    task automatic rst_chk;
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_0001)
        rd(ADDR_CONFIG, v, r);
        `CHK(v, 32'h0000_0000)
        `CHK(pins_out.gain, 5'h05)
    endtask

    initial begin
        cyc(8);
        rst <= 1'b0;
        rst_chk();
        // every gain code with random other bits, test bit 7 held at zero
        for (int c = 0; c < 4; c++) begin
            s = lfsr(s);
            d = {s[31:8], 1'b0, s[6], c[1:0], s[3:0]};
            wr(ADDR_CONFIG, d, r);
            `CHK(pins_out.gain, exp_gain(c[1:0]))
            `CHK(pins_out.amp_on, ~s[6])
            rd(ADDR_CONFIG, v, r);
            `CHK(v, {24'h0, d[7:0]})
        end
        // factory test output selected then left again
        wr(ADDR_DTIME, 32'h0000_0002, r);
        wr(ADDR_CONFIG, 32'h0000_0080, r);
        `CHK({pins_out.test_en, pins_out.test_src}, 3'h6)
        wr(ADDR_CONFIG, 32'h0000_0000, r);
        `CHK(pins_out.test_en, 1'b0)
        // reset flag sticks while enable is low
        wr(ADDR_STATUS, 32'h0000_0001, r);
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_0001)
        want.drv_en <= 1'b1;
        cyc(5);
        wr(ADDR_STATUS, 32'h0000_0001, r);
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_0000)
        // prewarning: clear refused while source still high
        want.temp_prewarn <= 1'b1;
        cyc(5);
        `CHK(pins_out.shutdown, 1'b0)
        wr(ADDR_STATUS, 32'h0000_0002, r);
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_0002)
        want.temp_prewarn <= 1'b0;
        cyc(5);
        wr(ADDR_STATUS, 32'h0000_0002, r);
        // overtemperature shutdown and fault output
        want.temp_over <= 1'b1;
        cyc(5);
        `CHK({pins_out.shutdown, pins_out.fault}, 2'h3)
        wr(ADDR_STATUS, 32'h0000_0004, r);
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_0004)
        want.temp_over <= 1'b0;
        cyc(5);
        wr(ADDR_STATUS, 32'h0000_0004, r);
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_0000)
        `CHK(pins_out.fault, 1'b0)
        // undervoltage flag latched, then cleared by writing one
        want.cp_undervolt <= 1'b1;
        cyc(5);
        want.cp_undervolt <= 1'b0;
        cyc(5);
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_0008)
        wr(ADDR_STATUS, 32'h0000_0008, r);
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_0000)
        // short, prewarning and overtemperature, then an enable cycle
        want.gate_inputs_on <= 1'b1;
        want.temp_prewarn <= 1'b1;
        want.temp_over <= 1'b1;
        want.short_event <= 1'b1;
        want.cp_undervolt <= 1'b1;
        cyc(4);
        want.temp_prewarn <= 1'b0;
        want.temp_over <= 1'b0;
        want.short_event <= 1'b0;
        want.cp_undervolt <= 1'b0;
        cyc(5);
        `CHK(pins_out.gate_block, 1'b1)
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_001E)
        want.drv_en <= 1'b0;
        cyc(5);
        want.drv_en <= 1'b1;
        cyc(5);
        rd(ADDR_STATUS, v, r);
        `CHK(v, 32'h0000_0002)
        `CHK(pins_out.gate_block, 1'b0)
        // unmapped address refused
        wr(32'h0000_0010, lfsr(s), r);
        `CHK(r, RESP_SLVERR)
        rd(32'h0000_0010, v, r);
        `CHK({r, v}, {RESP_SLVERR, 32'h0})
        // second reset in mid-run
        wr(ADDR_CONFIG, 32'h0000_0070, r);
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        rst_chk();
        tally_and_finish();
    end
endmodule
